// ---- rtl/cap_sense_compare_accumulate.sv ----
`timescale 1ns/1ns
`default_nettype none
module cap_sense_compare_accumulate (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire cs_pkg::sfr_wr_t SFR_WR_I,
    input wire logic SFR_RE_I,
    input wire logic [7:0] SFR_RD_ADDR_I,
    input wire logic GT_IRQ_EN_I,
    input wire logic [3:0] TIMER_OVF_I,
    input wire cs_pkg::sample_t SAMPLE_I,
    output logic [7:0] SFR_RDATA_O,
    output logic SENSE_EN_O,
    output logic SAMPLE_REQ_O,
    output logic [4:0] CHANNEL_O,
    output logic CONV_DONE_IRQ_O,
    output logic GT_IRQ_O,
    output logic WAKE_O
);

    typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_FINISH} state_t;

    state_t state_r;
    cs_pkg::start_mode_t mode_r;
    logic enable_r, cmp_en_r, done_r, gt_r, run_r, req_r, gt_irq_r, wake_r;
    logic [1:0] acu_r;
    logic [15:0] thr_r, result_r;
    logic [4:0] first_r, last_r, channel_r;
    logic [7:0] rdata_r;
    logic wr_ctrl, wr_cfg, wr_first, wr_last, wr_chan, wr_thh, wr_thl;
    logic is_idle, busy_wr, start_now, continuous, keep_going;
    logic result_v, result_gt, cmp_gt_event, halt;
    logic [15:0] acc_result;
    logic [7:0] ctrl_rd, cfg_rd;

    // modes in which a busy write starts a conversion
    function automatic logic busy_start_mode(input cs_pkg::start_mode_t m);
        busy_start_mode = (m == cs_pkg::MODE_BUSY_WRITE) || (m == cs_pkg::MODE_CONTINUOUS) ||
                          (m == cs_pkg::MODE_AUTO_SCAN);
    endfunction

    // timer overflow selected by the start mode; the order is not numeric
    function automatic logic timer_trigger(input cs_pkg::start_mode_t m, input logic [3:0] ovf);
        case (m)
            cs_pkg::MODE_TIMER0: timer_trigger = ovf[0];
            cs_pkg::MODE_TIMER2: timer_trigger = ovf[2];
            cs_pkg::MODE_TIMER1: timer_trigger = ovf[1];
            cs_pkg::MODE_TIMER3: timer_trigger = ovf[3];
            default: timer_trigger = 1'b0;
        endcase
    endfunction

    // next scan channel, wrapping to the first after the last
    function automatic logic [4:0] next_channel(input logic [4:0] cur, input logic [4:0] first,
                                                input logic [4:0] last);
        if (cur == last) begin
            next_channel = first;
        end else begin
            next_channel = 5'(cur + 5'h01);
        end
    endfunction

    // register write decode
    always_comb begin
        {wr_ctrl, wr_cfg, wr_first, wr_last, wr_chan, wr_thh, wr_thl} = 7'h00;
        if (SFR_WR_I.we && SFR_WR_I.addr == cs_pkg::ADDR_CONTROL) begin
            wr_ctrl = 1'b1;
        end else if (SFR_WR_I.we && SFR_WR_I.addr == cs_pkg::ADDR_CONFIG) begin
            wr_cfg = 1'b1;
        end else if (SFR_WR_I.we && SFR_WR_I.addr == cs_pkg::ADDR_SCAN_FIRST) begin
            wr_first = 1'b1;
        end else if (SFR_WR_I.we && SFR_WR_I.addr == cs_pkg::ADDR_SCAN_LAST) begin
            wr_last = 1'b1;
        end else if (SFR_WR_I.we && SFR_WR_I.addr == cs_pkg::ADDR_CHANNEL_SEL) begin
            wr_chan = 1'b1;
        end else if (SFR_WR_I.we && SFR_WR_I.addr == cs_pkg::ADDR_THRESH_HIGH) begin
            wr_thh = 1'b1;
        end else if (SFR_WR_I.we && SFR_WR_I.addr == cs_pkg::ADDR_THRESH_LOW) begin
            wr_thl = 1'b1;
        end
    end

    // start conditions and the comparator outcome of a finished result
    assign is_idle = (state_r == ST_IDLE);
    assign busy_wr = wr_ctrl && SFR_WR_I.data[cs_pkg::CTL_BUSY_BIT] && enable_r;
    assign start_now = enable_r && is_idle &&
                       ((busy_wr && busy_start_mode(mode_r)) ||
                        timer_trigger(mode_r, TIMER_OVF_I));
    assign continuous = (mode_r == cs_pkg::MODE_CONTINUOUS) || (mode_r == cs_pkg::MODE_AUTO_SCAN);
    assign result_gt = acc_result > thr_r;
    assign cmp_gt_event = result_v && cmp_en_r && result_gt;
    assign halt = cmp_gt_event && (mode_r == cs_pkg::MODE_AUTO_SCAN);
    assign keep_going = run_r && continuous && !halt;

    cs_accumulator u_acc (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .clear_i(!enable_r),
        .sample_valid_i(SAMPLE_I.valid && state_r == ST_SAMPLE),
        .sample_i(SAMPLE_I.data),
        .count_sel_i(acu_r),
        .result_valid_o(result_v),
        .result_o(acc_result)
    );

    // conversion sequencer; a result appears in the cycle after the last sample
    always_ff @(posedge CLK_I) begin
        if (RST_I || !enable_r) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_IDLE: if (start_now) state_r <= ST_SAMPLE;
                ST_SAMPLE: if (SAMPLE_I.valid) state_r <= ST_FINISH;
                ST_FINISH: state_r <= (result_v && !keep_going) ? ST_IDLE : ST_SAMPLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // one request per raw sample, more follow until the set is complete
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            req_r <= 1'b0;
        end else begin
            req_r <= enable_r && ((is_idle && start_now) ||
                     (state_r == ST_FINISH && (!result_v || keep_going)));
        end
    end

    // continuous run armed by a busy write, disarmed by a hit in auto-scan
    always_ff @(posedge CLK_I) begin
        if (RST_I || !enable_r || !continuous) begin
            run_r <= 1'b0;
        end else if (busy_wr) begin
            run_r <= 1'b1;
        end else if (halt) begin
            run_r <= 1'b0;
        end
    end

    // control bits written by software
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            enable_r <= 1'b0;
            cmp_en_r <= 1'b0;
        end else if (wr_ctrl) begin
            enable_r <= SFR_WR_I.data[cs_pkg::CTL_EN_BIT];
            cmp_en_r <= SFR_WR_I.data[cs_pkg::CTL_CMPEN_BIT];
        end
    end

    // done flag: a completing result wins over a clearing write
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            done_r <= 1'b0;
        end else if (result_v) begin
            done_r <= 1'b1;
        end else if (wr_ctrl) begin
            done_r <= SFR_WR_I.data[cs_pkg::CTL_DONE_BIT];
        end
    end

    // greater-than flag only moves on a compared result
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            gt_r <= 1'b0;
        end else if (result_v && cmp_en_r) begin
            gt_r <= result_gt;
        end
    end

    // event pulses; wake ignores the interrupt enable on purpose
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            gt_irq_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            gt_irq_r <= cmp_gt_event && GT_IRQ_EN_I;
            wake_r <= cmp_gt_event;
        end
    end

    // configuration; changing the count mid-set garbles that one result
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            mode_r <= cs_pkg::MODE_BUSY_WRITE;
            acu_r <= cs_pkg::ACU_RST;
        end else if (wr_cfg) begin
            mode_r <= cs_pkg::start_mode_t'(SFR_WR_I.data[cs_pkg::CFG_MODE_LSB +: 3]);
            acu_r <= SFR_WR_I.data[cs_pkg::CFG_ACU_LSB +: 2];
        end
    end

    // threshold bytes
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            thr_r <= cs_pkg::WORD_RST;
        end else if (wr_thh) begin
            thr_r[15:8] <= SFR_WR_I.data;
        end else if (wr_thl) begin
            thr_r[7:0] <= SFR_WR_I.data;
        end
    end

    // stored result
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            result_r <= cs_pkg::WORD_RST;
        end else if (result_v) begin
            result_r <= acc_result;
        end
    end

    // scan bounds
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            first_r <= cs_pkg::CHAN_RST;
            last_r <= cs_pkg::CHAN_RST;
        end else if (wr_first) begin
            first_r <= SFR_WR_I.data[4:0];
        end else if (wr_last) begin
            last_r <= SFR_WR_I.data[4:0];
        end
    end

    // channel select; software writes win over the scan step
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            channel_r <= cs_pkg::CHAN_RST;
        end else if (wr_chan || (wr_first && mode_r == cs_pkg::MODE_AUTO_SCAN)) begin
            channel_r <= SFR_WR_I.data[4:0];
        end else if (result_v && mode_r == cs_pkg::MODE_AUTO_SCAN && !cmp_gt_event) begin
            channel_r <= next_channel(channel_r, first_r, last_r);
        end
    end

    // read views; unused bits are constant zero
    assign ctrl_rd = {enable_r, 1'b0, done_r, !is_idle, cmp_en_r, 2'h0, gt_r};
    assign cfg_rd = {1'b0, mode_r, 2'h0, acu_r};

    // registered read data, unmapped addresses return zero
    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            rdata_r <= cs_pkg::BYTE_RST;
        end else if (SFR_RE_I) begin
            if (SFR_RD_ADDR_I == cs_pkg::ADDR_CONTROL) begin
                rdata_r <= ctrl_rd;
            end else if (SFR_RD_ADDR_I == cs_pkg::ADDR_CONFIG) begin
                rdata_r <= cfg_rd;
            end else if (SFR_RD_ADDR_I == cs_pkg::ADDR_RESULT_HIGH) begin
                rdata_r <= result_r[15:8];
            end else if (SFR_RD_ADDR_I == cs_pkg::ADDR_RESULT_LOW) begin
                rdata_r <= result_r[7:0];
            end else if (SFR_RD_ADDR_I == cs_pkg::ADDR_SCAN_FIRST) begin
                rdata_r <= {3'h0, first_r};
            end else if (SFR_RD_ADDR_I == cs_pkg::ADDR_SCAN_LAST) begin
                rdata_r <= {3'h0, last_r};
            end else if (SFR_RD_ADDR_I == cs_pkg::ADDR_CHANNEL_SEL) begin
                rdata_r <= {3'h0, channel_r};
            end else if (SFR_RD_ADDR_I == cs_pkg::ADDR_THRESH_HIGH) begin
                rdata_r <= thr_r[15:8];
            end else if (SFR_RD_ADDR_I == cs_pkg::ADDR_THRESH_LOW) begin
                rdata_r <= thr_r[7:0];
            end else begin
                rdata_r <= cs_pkg::BYTE_RST;
            end
        end
    end

    assign SFR_RDATA_O = rdata_r;
    assign SENSE_EN_O = enable_r;
    assign SAMPLE_REQ_O = req_r;
    assign CHANNEL_O = channel_r;
    assign CONV_DONE_IRQ_O = done_r;
    assign GT_IRQ_O = gt_irq_r;
    assign WAKE_O = wake_r;

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    sequence s_final_sample;
        state_r == ST_SAMPLE && SAMPLE_I.valid && enable_r ##1 result_v;
    endsequence

    a_gt_above: assert property (result_v && cmp_en_r && result_gt |=> gt_r)
        else $error("flag not set for result above threshold");
    a_gt_below: assert property (result_v && cmp_en_r && !result_gt |=> !gt_r)
        else $error("flag not cleared for result at or below threshold");
    a_gt_final_only: assert property (!result_v || !cmp_en_r |=> gt_r == $past(gt_r))
        else $error("flag moved without a compared result");
    a_gt_irq_gate: assert property (GT_IRQ_O |-> $past(GT_IRQ_EN_I) && gt_r)
        else $error("greater-than request without enable or flag");
    a_scan_halt: assert property (halt && !busy_wr |=> is_idle && !SAMPLE_REQ_O && !run_r)
        else $error("auto-scan kept running after a hit");
    a_wake_event: assert property (cmp_gt_event |=> WAKE_O)
        else $error("no wake after greater-than event");
    a_done_after_set: assert property (s_final_sample |=> CONV_DONE_IRQ_O)
        else $error("done flag missing after final sample");
    a_done_sticky: assert property (done_r && !wr_ctrl |=> done_r)
        else $error("done flag cleared by hardware");
    a_chan_step: assert property (result_v && mode_r == cs_pkg::MODE_AUTO_SCAN && !cmp_gt_event
        && !wr_chan && !wr_first && channel_r != last_r |=> channel_r == 5'($past(channel_r) + 5'h01))
        else $error("scan channel did not step");
    a_chan_hold: assert property (cmp_gt_event && !wr_chan && !wr_first |=> $stable(channel_r))
        else $error("channel moved after a hit");
    a_disabled_idle: assert property (!enable_r |=> is_idle && !SAMPLE_REQ_O)
        else $error("unit active while disabled");
    a_busy_zero_write: assert property (is_idle && !start_now |=> is_idle)
        else $error("conversion started without a trigger");
    a_unused_zero: assert property (SFR_RE_I && SFR_RD_ADDR_I == cs_pkg::ADDR_CONTROL
        |=> SFR_RDATA_O[6] == 1'b0 && SFR_RDATA_O[2:1] == 2'h0)
        else $error("unused control bits read nonzero");

endmodule
`default_nettype wire

// ---- rtl/cs_pkg.sv ----
package cs_pkg;

    // data path widths
    localparam int SAMPLE_W = 16;
    localparam int ACC_W = 20;
    localparam int CHAN_W = 5;

    // special-function-register addresses
    localparam logic [7:0] ADDR_CONTROL = 8'h9A;
    localparam logic [7:0] ADDR_CONFIG = 8'h9E;
    localparam logic [7:0] ADDR_RESULT_HIGH = 8'hAA;
    localparam logic [7:0] ADDR_RESULT_LOW = 8'hA9;
    localparam logic [7:0] ADDR_SCAN_FIRST = 8'h92;
    localparam logic [7:0] ADDR_SCAN_LAST = 8'h93;
    localparam logic [7:0] ADDR_THRESH_HIGH = 8'h97;
    localparam logic [7:0] ADDR_THRESH_LOW = 8'h96;
    localparam logic [7:0] ADDR_CHANNEL_SEL = 8'h9C;

    // sense_control field positions
    localparam int CTL_EN_BIT = 7;
    localparam int CTL_DONE_BIT = 5;
    localparam int CTL_BUSY_BIT = 4;
    localparam int CTL_CMPEN_BIT = 3;
    localparam int CTL_GT_BIT = 0;

    // sense_config field positions
    localparam int CFG_MODE_LSB = 4;
    localparam int CFG_ACU_LSB = 0;

    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [4:0] CHAN_RST = 5'h00;
    localparam logic [1:0] ACU_RST = 2'h0;

    // conversion trigger selection
    typedef enum logic [2:0] {
        MODE_BUSY_WRITE = 3'h0,
        MODE_TIMER0 = 3'h1,
        MODE_TIMER2 = 3'h2,
        MODE_TIMER1 = 3'h3,
        MODE_TIMER3 = 3'h4,
        MODE_RESERVED = 3'h5,
        MODE_CONTINUOUS = 3'h6,
        MODE_AUTO_SCAN = 3'h7
    } start_mode_t;

    // one register write from the core
    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } sfr_wr_t;

    // one raw conversion from the front end
    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] data;
    } sample_t;

endpackage

// ---- rtl/cs_accumulator.sv ----
`timescale 1ns/1ns
`default_nettype none
module cs_accumulator (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic sample_valid_i,
    input wire logic [15:0] sample_i,
    input wire logic [1:0] count_sel_i,
    output logic result_valid_o,
    output logic [15:0] result_o
);

    logic [19:0] acc_r;
    logic [4:0] count_r;
    logic [19:0] sum;
    logic final_sample;

    // samples per result for each accumulate setting
    function automatic logic [4:0] target(input logic [1:0] sel);
        case (sel)
            2'h0: target = 5'h01;
            2'h1: target = 5'h04;
            2'h2: target = 5'h08;
            default: target = 5'h10;
        endcase
    endfunction

    // divide by the count is a plain shift since all counts are powers of two
    function automatic logic [2:0] shift(input logic [1:0] sel);
        case (sel)
            2'h0: shift = 3'h0;
            2'h1: shift = 3'h2;
            2'h2: shift = 3'h3;
            default: shift = 3'h4;
        endcase
    endfunction

    assign sum = acc_r + {4'h0, sample_i};
    assign final_sample = (5'(count_r + 5'h01) == target(count_sel_i));

    // running sum, restarted after each finished set
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            acc_r <= 20'h00000;
            count_r <= 5'h00;
        end else if (sample_valid_i) begin
            if (final_sample) begin
                acc_r <= 20'h00000;
                count_r <= 5'h00;
            end else begin
                acc_r <= sum;
                count_r <= 5'(count_r + 5'h01);
            end
        end
    end

    // 16 of 20 bits survive the divide for every setting
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i) begin
            result_valid_o <= 1'b0;
            result_o <= 16'h0000;
        end else begin
            result_valid_o <= sample_valid_i && final_sample;
            if (sample_valid_i && final_sample) begin
                result_o <= 16'(sum >> shift(count_sel_i));
            end
        end
    end

    a_single_pass: assert property (@(posedge clk_i) disable iff (rst_i)
        sample_valid_i && !clear_i && count_sel_i == 2'h0 && count_r == 5'h00
        |=> result_valid_o && result_o == $past(sample_i))
        else $error("single-sample result differs from sample");
    a_count_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        result_valid_o |-> count_r == 5'h00 && acc_r == 20'h00000)
        else $error("accumulator not restarted after a result");

endmodule
`default_nettype wire

// ---- verif/cs_front_end_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module cs_front_end_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req_i,
    input wire logic en_i,
    input wire logic clr_i,
    input wire logic [15:0] base_i,
    input wire logic [3:0] dly_i,
    output var cs_pkg::sample_t smp_o
);
    logic [3:0] wait_r;
    logic [15:0] cnt_r;
    logic [15:0] last_r;
    // one answer per request after dly_i cycles; successive answers fall by 4
    always_ff @(posedge clk_i) begin
        smp_o.valid <= 1'b0;
        smp_o.data <= ~last_r; // no stale value left on the bus between answers
        if (clr_i) begin
            cnt_r <= 16'h0000;
        end
        if (rst_i || !en_i) begin
            wait_r <= 4'h0;
            last_r <= 16'h0000;
            cnt_r <= 16'h0000;
        end else if (req_i) begin
            wait_r <= dly_i;
        end else if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
            if (wait_r == 4'h1) begin
                smp_o.valid <= 1'b1;
                smp_o.data <= base_i - (cnt_r << 2);
                last_r <= base_i - (cnt_r << 2);
                cnt_r <= cnt_r + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ---- verif/cap_sense_compare_accumulate_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module cap_sense_compare_accumulate_test;
    logic clk, rst, re, gt_en, clr, sen, req, done, gt, wake, done_d;
    logic [7:0] ra, rdata;
    logic [3:0] tmr, dly;
    logic [15:0] base;
    logic [4:0] ch;
    logic [4:0] ch_q [0:63];
    cs_pkg::sfr_wr_t wr;
    cs_pkg::sample_t smp;
    int bad_count, check_count, req_n, gt_n, wake_n, done_n, n0, w0, m, k;
    int tbit [1:4] = '{0, 2, 1, 3};
    cap_sense_compare_accumulate i_cap_sense_compare_accumulate (.CLK_I(clk), .RST_I(rst),
        .SFR_WR_I(wr), .SFR_RE_I(re), .SFR_RD_ADDR_I(ra), .GT_IRQ_EN_I(gt_en),
        .TIMER_OVF_I(tmr), .SAMPLE_I(smp), .SFR_RDATA_O(rdata), .SENSE_EN_O(sen),
        .SAMPLE_REQ_O(req), .CHANNEL_O(ch), .CONV_DONE_IRQ_O(done), .GT_IRQ_O(gt),
        .WAKE_O(wake));
    cs_front_end_model i_cs_front_end_model (.clk_i(clk), .rst_i(rst), .req_i(req), .en_i(sen),
        .clr_i(clr), .base_i(base), .dly_i(dly), .smp_o(smp));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // event counters; channel captured at each request
    initial {req_n, gt_n, wake_n, done_n} = '0;
    always @(posedge clk) begin
        done_d <= done;
        if (req === 1'b1) begin
            ch_q[req_n % 64] <= ch;
            req_n <= req_n + 1;
        end
        if (gt === 1'b1) gt_n <= gt_n + 1;
        if (wake === 1'b1) wake_n <= wake_n + 1;
        if (done === 1'b1 && done_d !== 1'b1) done_n <= done_n + 1;
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #1 wr = {1'b1, a, d};
        @(posedge clk);
        #1 wr = '0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        #1 re = 1'b1;
        ra = a;
        @(posedge clk);
        #1 re = 1'b0;
        chk({8'h00, rdata}, {8'h00, exp});
    endtask
    // bounded wait on one of the event counters
    task automatic wait_cnt(ref int c, input int n);
        for (int i = 0; i < 600 && c < n; i++) begin
            @(posedge clk);
            #1;
        end
        if (c < n) begin
            bad_count++;
            wrap_up();
        end
    endtask
    task automatic pulse_tmr(input logic [3:0] t);
        @(posedge clk);
        #1 tmr = t;
        @(posedge clk);
        #1 tmr = 4'h0;
    endtask
    initial begin
        rst = 1'b1;
        wr = '0;
        {re, clr, tmr, ra} = '0;
        gt_en = 1'b1;
        base = 16'h1239;
        dly = 4'h1;
        repeat (12) @(posedge clk);
        #1 rst = 1'b0;
        rd_chk(cs_pkg::ADDR_CONTROL, 8'h00);
        rd_chk(8'hFF, 8'h00);
        wr_reg(cs_pkg::ADDR_CONTROL, 8'hCE);
        rd_chk(cs_pkg::ADDR_CONTROL, 8'h88);
        chk({15'h0, sen}, 16'h0001);
        wr_reg(cs_pkg::ADDR_THRESH_HIGH, 8'h12);
        wr_reg(cs_pkg::ADDR_THRESH_LOW, 8'h34);
        rd_chk(cs_pkg::ADDR_THRESH_HIGH, 8'h12);
        // comparator off: flag and wake untouched
        wr_reg(cs_pkg::ADDR_CONTROL, 8'h90);
        wait_cnt(done_n, 1);
        rd_chk(cs_pkg::ADDR_RESULT_HIGH, 8'h12);
        rd_chk(cs_pkg::ADDR_RESULT_LOW, 8'h39);
        rd_chk(cs_pkg::ADDR_CONTROL, 8'hA0);
        chk(16'(wake_n), 16'h0000);
        wr_reg(cs_pkg::ADDR_CONTROL, 8'h98);
        wait_cnt(done_n, 2);
        repeat (20) @(posedge clk);
        rd_chk(cs_pkg::ADDR_CONTROL, 8'hA9);
        chk(16'(gt_n), 16'h0001);
        chk(16'(wake_n), 16'h0001);
        wr_reg(cs_pkg::ADDR_CONTROL, 8'h88);
        rd_chk(cs_pkg::ADDR_CONTROL, 8'h89);
        // equal to threshold, slow answer, interrupt enable off
        base = 16'h123C; // third answer of the model lands exactly on the threshold
        gt_en = 1'b0;
        dly = 4'hC;
        wr_reg(cs_pkg::ADDR_CONTROL, 8'h98);
        rd_chk(cs_pkg::ADDR_CONTROL, 8'h99);
        wait_cnt(done_n, 3);
        rd_chk(cs_pkg::ADDR_CONTROL, 8'hA8);
        base = 16'h2010;
        wr_reg(cs_pkg::ADDR_CONTROL, 8'h98);
        wait_cnt(done_n, 4);
        chk(16'(gt_n), 16'h0001);
        chk(16'(wake_n), 16'h0002);
        // accumulation: first samples exceed threshold, only some averages do
        dly = 4'h1;
        wr_reg(cs_pkg::ADDR_THRESH_HIGH, 8'h20);
        wr_reg(cs_pkg::ADDR_THRESH_LOW, 8'h0B);
        for (k = 0; k < 4; k++) begin
            m = (k == 0) ? 1 : (4 << (k - 1));
            pulse_tmr(4'h0);
            clr = 1'b1;
            @(posedge clk);
            #1 clr = 1'b0;
            wr_reg(cs_pkg::ADDR_CONFIG, {6'h00, 2'(k)});
            {n0, w0} = {req_n, wake_n};
            wr_reg(cs_pkg::ADDR_CONTROL, 8'h98);
            wait_cnt(done_n, 5 + k);
            rd_chk(cs_pkg::ADDR_RESULT_HIGH, 8'((16'h2010 - 16'(2 * (m - 1))) >> 8));
            rd_chk(cs_pkg::ADDR_RESULT_LOW, 8'(16'h2010 - 16'(2 * (m - 1))));
            chk(16'(req_n - n0), 16'(m));
            chk(16'(wake_n - w0), 16'(k == 0));
        end
        // timer start modes; busy write ignored there and in the reserved mode
        for (k = 1; k < 6; k++) begin
            wr_reg(cs_pkg::ADDR_CONFIG, {1'b0, 3'(k), 4'h0});
            n0 = req_n;
            wr_reg(cs_pkg::ADDR_CONTROL, 8'h98);
            repeat (20) @(posedge clk);
            chk(16'(req_n - n0), 16'h0000);
            if (k < 5) begin
                pulse_tmr(4'h1 << tbit[k]);
                wait_cnt(done_n, 8 + k);
            end
        end
        // auto-scan over channels 2..3, then a hit halts it
        wr_reg(cs_pkg::ADDR_THRESH_HIGH, 8'hFF);
        wr_reg(cs_pkg::ADDR_CONFIG, 8'h70);
        wr_reg(cs_pkg::ADDR_SCAN_FIRST, 8'h02);
        wr_reg(cs_pkg::ADDR_SCAN_LAST, 8'h03);
        n0 = req_n;
        wr_reg(cs_pkg::ADDR_CONTROL, 8'h98);
        wait_cnt(req_n, n0 + 4);
        for (k = 0; k < 4; k++) chk({11'h0, ch_q[(n0 + k) % 64]}, 16'(2 + k % 2));
        w0 = wake_n;
        wr_reg(cs_pkg::ADDR_THRESH_HIGH, 8'h00);
        wait_cnt(wake_n, w0 + 1);
        repeat (2) @(posedge clk);
        n0 = req_n;
        repeat (40) @(posedge clk);
        chk(16'(req_n - n0), 16'h0000);
        chk({11'h0, ch}, {11'h0, ch_q[(n0 - 1) % 64]});
        wr_reg(cs_pkg::ADDR_CONTROL, 8'h98);
        wait_cnt(req_n, n0 + 1);
        wr_reg(cs_pkg::ADDR_CONTROL, 8'h00);
        chk({15'h0, sen}, 16'h0000);
        n0 = req_n;
        repeat (30) @(posedge clk);
        chk(16'(req_n - n0), 16'h0000);
        wrap_up();
    end
endmodule
`default_nettype wire
